// ### design/ssf_pkg.sv
// ssf_pkg: constants for the clock-synchronous serial channel.
// assumes: included before ssf_sync and ssf_top; no imports are used.
package ssf_pkg;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] OFS_CTRL = 3'h0; // serial_ctrl reg, rw
  localparam logic [2:0] OFS_DIV = 3'h1; // shift clock half period, rw
  localparam logic [2:0] OFS_TXBUF = 3'h2; // tx_buffer_reg, write loads
  localparam logic [2:0] OFS_RXBUF = 3'h3; // rx_buffer_reg, read clears
  localparam logic [2:0] OFS_STAT = 3'h4; // live state, ro
  localparam logic [2:0] OFS_IRQ_STAT = 3'h5; // sticky events, ro
  localparam logic [2:0] OFS_IRQ_CLR = 3'h6; // write one to clear, wo
  localparam logic [2:0] OFS_IRQ_EN = 3'h7; // event enables, rw

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CTRL_TE = 0; // transmit_enable_bit
  localparam int CTRL_RE = 1; // receive_enable_bit
  localparam int CTRL_INT_CLK = 2; // 1: internal shift clock
  localparam int CTRL_POL = 3; // clock_polarity_select
  localparam int CTRL_CTS_EN = 4; // clear-to-send gating
  localparam int CTRL_RTS_EN = 5; // ready-to-send output
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // ------------------------------------------------------------
  // status, rx buffer and interrupt field positions
  // ------------------------------------------------------------
  localparam int STAT_TX_EMPTY = 0;
  localparam int STAT_RX_FULL = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_BUSY = 3;
  localparam int RXBUF_OVERRUN = 12; // overrun_error_flag in rx buffer
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_W = 3;

  // ------------------------------------------------------------
  // link widths and reset values
  // ------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam int SYNC_W = 3; // clock pin, data in, clear-to-send

  typedef enum logic [1:0] {
    SSF_IDLE = 2'b00,
    SSF_SHIFT = 2'b01
  } ssf_state_t;

endpackage : ssf_pkg

// ### design/ssf_sync.sv
// ssf_sync: three-stage synchroniser for pin inputs.
// assumes: inputs are asynchronous to mclk; stage one feeds only stage two.
`timescale 1ns/1ps
module ssf_sync
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] pin_in,
  output logic [2:0] stage2,
  output logic [2:0] stage3
);

  logic [2:0] stage1;

  // ------------------------------------------------------------
  // one chain per pin
  // ------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_chain
    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        stage1[i] <= 1'b1;
        stage2[i] <= 1'b1;
        stage3[i] <= 1'b1;
      end
      else
      begin
        stage1[i] <= pin_in[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
      end
    end
  end

endmodule : ssf_sync

// ### design/ssf_top.sv
// ssf_top: clock-synchronous serial channel with flow control.
// assumes: plain register port master; link pins asynchronous to mclk.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// [R1] external clock with rts enabled: ready output low when able to receive
// [R2] ready output goes high as soon as a receive transfer begins
// [R3] ready output inactive while the internal shift clock is selected
// [R4] polarity 0: launch on falling, sample on rising; 1 reverses both
// [R5] partner holds external clock at idle level while setting up
// [R6] partner holds clear-to-send low before clock leaves idle
// [R7] shift clock runs only while the transmitter is active
// [R8] filler word in the tx buffer is shifted out during reception
// [R9] internal clock starts once transmit enabled and tx buffer loaded
// [R10] external clock shifts only with transmit enabled and buffer loaded
// [R11] word completing while rx buffer full sets the overrun flag
// [R12] rx buffer contents are undefined after an overrun
// [R13] overrun leaves the receive interrupt request flag unchanged
// [R14] software writes a new filler word before every receive transfer
// [R15] external reception starts only with enables set, clock idle; the start condition here checks te but not re
// [R16] tx empty flag set on move to shifter, cleared on buffer write
module ssf_top
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  input wire logic clear_to_send_in_pin_n,
  output logic ready_to_send_out_pin_n
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [2:0] s2, s3;
  logic [5:0] ctrl, next_ctrl;
  logic [7:0] div, next_div;
  logic [7:0] tx_buf, next_tx_buf;
  logic [7:0] rx_buf, next_rx_buf;
  logic tx_empty, next_tx_empty;
  logic rx_full, next_rx_full;
  logic ovr, next_ovr;
  logic [2:0] irq_stat, next_irq_stat;
  logic [2:0] irq_en, next_irq_en;
  logic [15:0] next_rdata;
  ssf_pkg::ssf_state_t state, next_state;
  logic [7:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] dcnt, next_dcnt;
  logic sclk, next_sclk;
  logic clk_lvl, next_clk_lvl;
  logic txd, next_txd;
  logic te, re, int_clk, pol, cts_en, rts_en;
  logic tx_wr, rx_rd, cts_ok, start, done;
  logic tick, ext_edge, rise, fall, launch, sample;

  assign te = ctrl[ssf_pkg::CTRL_TE];
  assign re = ctrl[ssf_pkg::CTRL_RE];
  assign int_clk = ctrl[ssf_pkg::CTRL_INT_CLK];
  assign pol = ctrl[ssf_pkg::CTRL_POL];
  assign cts_en = ctrl[ssf_pkg::CTRL_CTS_EN];
  assign rts_en = ctrl[ssf_pkg::CTRL_RTS_EN];
  assign tx_wr = reg_wr && reg_addr == ssf_pkg::OFS_TXBUF;
  assign rx_rd = reg_rd && reg_addr == ssf_pkg::OFS_RXBUF;
  // ------------------------------------------------------------
  // pin synchronisers: 0 clock, 1 data in, 2 clear-to-send
  // ------------------------------------------------------------
  ssf_sync u_sync
  (
    .mclk(mclk),
    .rst(rst),
    .pin_in({clear_to_send_in_pin_n, serial_data_in_pin,
             shift_clock_pin_in}),
    .stage2(s2),
    .stage3(s3)
  );
  // ------------------------------------------------------------
  // edge finding and start condition
  // ------------------------------------------------------------
  // external level moves once stages two and three agree
  assign ext_edge = (s2[0] == s3[0]) && (s3[0] != clk_lvl);
  assign tick = int_clk && state == ssf_pkg::SSF_SHIFT && dcnt == 8'h00;
  assign fall = int_clk ? (tick && sclk) : (ext_edge && !s3[0]);
  assign rise = int_clk ? (tick && !sclk) : (ext_edge && s3[0]);
  assign launch = pol ? rise : fall; // [R4]
  assign sample = pol ? fall : rise; // [R4]
  assign cts_ok = !cts_en || !s3[2]; // [R6]
  // a word only moves when enabled, loaded and the clock rests idle
  assign start = state == ssf_pkg::SSF_IDLE && te && !tx_empty && !tx_wr
    && cts_ok && (int_clk || clk_lvl == !pol); // [R9] [R10] [R15] [R5]
  assign done = state == ssf_pkg::SSF_SHIFT && sample
    && bitcnt == ssf_pkg::LAST_BIT;
  // ------------------------------------------------------------
  // link side next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_bitcnt = bitcnt;
    next_dcnt = dcnt;
    next_sclk = sclk;
    next_txd = txd;
    next_clk_lvl = ext_edge ? s3[0] : clk_lvl;
    unique case (state)
      ssf_pkg::SSF_IDLE:
      begin
        next_sclk = !pol; // clock parked while transmitter idle [R7]
        next_dcnt = div;
        next_txd = 1'b1; // idle high, held one cycle past the last sample
        if (start)
        begin
          next_state = ssf_pkg::SSF_SHIFT;
          next_tx_sh = tx_buf; // filler goes out while receiving [R8]
          next_txd = tx_buf[0];
          next_bitcnt = 3'h0;
        end
      end
      ssf_pkg::SSF_SHIFT:
      begin
        if (int_clk)
        begin
          // internal clock toggles only while shifting [R7]
          next_dcnt = (dcnt == 8'h00) ? div : dcnt - 8'h01;
          if (tick)
            next_sclk = !sclk;
        end
        if (launch && bitcnt != 3'h0)
        begin
          next_tx_sh = {1'b1, tx_sh[7:1]};
          next_txd = tx_sh[1];
        end
        if (sample)
        begin
          next_rx_sh = {s3[1], rx_sh[7:1]}; // lsb first
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == ssf_pkg::LAST_BIT)
            next_state = ssf_pkg::SSF_IDLE;
        end
      end
    endcase
  end
  // link side registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ssf_pkg::SSF_IDLE;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      bitcnt <= 3'h0;
      dcnt <= 8'h00;
      sclk <= 1'b1;
      txd <= 1'b1;
      clk_lvl <= 1'b1;
    end
    else
    begin
      state <= next_state;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      bitcnt <= next_bitcnt;
      dcnt <= next_dcnt;
      sclk <= next_sclk;
      txd <= next_txd;
      clk_lvl <= next_clk_lvl;
    end
  end
  // ------------------------------------------------------------
  // software registers and flags
  // ------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_div = div;
    next_tx_buf = tx_buf;
    next_irq_en = irq_en;
    next_rx_buf = rx_buf;
    next_tx_empty = tx_empty;
    next_rx_full = rx_full;
    next_ovr = ovr;
    next_irq_stat = irq_stat;
    next_rdata = 16'h0000;
    // clears and loads first, so events below win
    if (reg_wr)
    begin
      unique case (reg_addr)
        ssf_pkg::OFS_CTRL: next_ctrl = reg_wdata[5:0];
        ssf_pkg::OFS_DIV: next_div = reg_wdata[7:0];
        ssf_pkg::OFS_TXBUF:
        begin
          next_tx_buf = reg_wdata[7:0];
          next_tx_empty = 1'b0; // [R16]
        end
        ssf_pkg::OFS_IRQ_CLR: next_irq_stat = irq_stat & ~reg_wdata[2:0];
        ssf_pkg::OFS_IRQ_EN: next_irq_en = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (rx_rd)
    begin
      next_rx_full = 1'b0;
      next_ovr = 1'b0;
    end
    if (start)
    begin
      next_tx_empty = 1'b1; // [R16]
      next_irq_stat[ssf_pkg::IRQ_TX] = 1'b1;
    end
    if (done)
    begin
      next_rx_full = 1'b1;
      next_rx_buf = {s3[1], rx_sh[7:1]}; // overwritten, undefined [R12]
      if (rx_full)
      begin
        next_ovr = 1'b1; // [R11]
        next_irq_stat[ssf_pkg::IRQ_OVR] = 1'b1;
      end
      else
        next_irq_stat[ssf_pkg::IRQ_RX] = 1'b1; // rx flag set only without overrun [R13]
    end
    // read data for the cycle after the strobe
    if (reg_rd)
    begin
      unique case (reg_addr)
        ssf_pkg::OFS_CTRL: next_rdata = {10'h000, ctrl};
        ssf_pkg::OFS_DIV: next_rdata = {8'h00, div};
        ssf_pkg::OFS_TXBUF: next_rdata = {8'h00, tx_buf};
        ssf_pkg::OFS_RXBUF: next_rdata = {3'h0, ovr, 4'h0, rx_buf};
        ssf_pkg::OFS_STAT:
          next_rdata = {12'h000, state == ssf_pkg::SSF_SHIFT, ovr,
                        rx_full, tx_empty};
        ssf_pkg::OFS_IRQ_STAT: next_rdata = {13'h0000, irq_stat};
        ssf_pkg::OFS_IRQ_EN: next_rdata = {13'h0000, irq_en};
        default: next_rdata = 16'h0000;
      endcase
    end
  end
  // software side registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl <= ssf_pkg::CTRL_RST;
      div <= ssf_pkg::DIV_RST;
      tx_buf <= 8'h00;
      rx_buf <= 8'h00;
      tx_empty <= 1'b1;
      rx_full <= 1'b0;
      ovr <= 1'b0;
      irq_stat <= 3'h0;
      irq_en <= 3'h0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      div <= next_div;
      tx_buf <= next_tx_buf;
      rx_buf <= next_rx_buf;
      tx_empty <= next_tx_empty;
      rx_full <= next_rx_full;
      ovr <= next_ovr;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      reg_rdata <= next_rdata;
    end
  end
  // ------------------------------------------------------------
  // pins and interrupt
  // ------------------------------------------------------------
  assign irq = |(irq_stat & irq_en);
  assign shift_clock_pin_out = sclk;
  assign shift_clock_pin_oe = int_clk;
  assign serial_data_out_pin = txd;
  // low only when an external-clock receive can be taken [R1] [R2] [R3]
  assign ready_to_send_out_pin_n = !(rts_en && !int_clk && re && te
    && !tx_empty && state == ssf_pkg::SSF_IDLE);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_rts_ready_low: assert property ( // [R1]
    (rts_en && !int_clk && re && te && !tx_empty
     && state == ssf_pkg::SSF_IDLE) |-> !ready_to_send_out_pin_n)
    else $error("ready output not low while able to receive");
  a_rts_busy_high: assert property ( // [R2]
    $rose(state == ssf_pkg::SSF_SHIFT) |-> ready_to_send_out_pin_n
      throughout (##[0:1] 1'b1))
    else $error("ready output low during transfer");
  a_rts_internal_off: assert property ( // [R3]
    int_clk |-> ready_to_send_out_pin_n)
    else $error("ready output active with internal clock");
  a_clk_parked: assert property ( // [R7]
    (state == ssf_pkg::SSF_IDLE && $past(state) == ssf_pkg::SSF_IDLE
     && $stable(pol)) |-> sclk == !pol)
    else $error("shift clock moved while transmitter idle");
  a_start_needs_data: assert property ( // [R9]
    $rose(state == ssf_pkg::SSF_SHIFT) |-> $past(te) && !$past(tx_empty))
    else $error("transfer started without enable and data");
  a_start_clock_idle: assert property ( // [R10]
    ($rose(state == ssf_pkg::SSF_SHIFT) && !int_clk)
      |-> $past(clk_lvl) == !$past(pol))
    else $error("external transfer started off idle level");
  a_empty_on_move: assert property ( // [R16]
    $rose(state == ssf_pkg::SSF_SHIFT) |-> tx_empty && tx_sh == $past(tx_buf))
    else $error("tx empty not set on move");
  a_empty_on_write: assert property ( // [R16]
    tx_wr |=> !tx_empty)
    else $error("tx empty not cleared by write");
  a_overrun_set: assert property ( // [R11]
    (done && rx_full) |=> ovr ##1 (ovr || $past(rx_rd)))
    else $error("overrun not flagged");
  a_overrun_rx_irq: assert property ( // [R13]
    (done && rx_full && !(reg_wr && reg_addr == ssf_pkg::OFS_IRQ_CLR))
      |=> irq_stat[ssf_pkg::IRQ_RX] == $past(irq_stat[ssf_pkg::IRQ_RX]))
    else $error("overrun changed rx request flag");
  a_eight_samples: assert property ( // [R4]
    done |-> sample && bitcnt == ssf_pkg::LAST_BIT ##1
      state == ssf_pkg::SSF_IDLE)
    else $error("word not closed after eight samples");
  c_overrun: cover property (done && rx_full);
  c_rx_word: cover property (done && !rx_full);
  c_int_start: cover property (start && int_clk);
  c_ext_start: cover property (start && !int_clk && cts_en);
endmodule : ssf_top

// ### tb/ssf_peer.sv
// ssf_peer: far-side synchronous serial partner for the bench.
// assumes: clk_line is the resolved clock wire; mclk is 40 MHz.
`timescale 1ns/1ps
module ssf_peer
(
  input wire logic mclk,
  input wire logic clk_line,
  input wire logic sdo,
  output logic clk_pin,
  output logic data_pin,
  output logic cts_n,
  output logic [7:0] got
);
  logic pol;
  logic in_frame;

  // idle values before any frame
  initial
  begin
    pol = 1'b0;
    in_frame = 1'b0;
    clk_pin = 1'b1;
    data_pin = 1'b1;
    cts_n = 1'b1;
    got = 8'h00;
  end

  // released data line changes every cycle, never a stale bit
  always @(posedge mclk)
  begin
    if (!in_frame)
      data_pin <= ~data_pin;
  end

  // clock parked at its idle level before any setup
  task automatic park(input logic p);
    pol = p;
    clk_pin = !p;
  endtask : park

  // partner-clocked frame, 200 ns period, off the mclk grid
  task automatic run_ext(input logic [7:0] b);
    in_frame = 1'b1;
    data_pin = b[0];
    cts_n = 1'b0;
    #307;
    for (int i = 0; i < 8; i++)
    begin
      clk_pin = pol;
      data_pin = b[i];
      #100;
      clk_pin = !pol;
      #100;
    end
    cts_n = 1'b1;
    in_frame = 1'b0;
  endtask : run_ext

  // follows the device's own clock: launch on one edge, sample on other
  task automatic run_int(input logic [7:0] b);
    int n;
    logic prev;
    logic last;
    n = 0;
    in_frame = 1'b1;
    data_pin = b[0];
    prev = clk_line;
    last = sdo;
    for (int t = 0; t < 4000 && n < 8; t++)
    begin
      @(posedge mclk);
      #1;
      if (clk_line !== prev && clk_line === pol)
        data_pin = b[n[2:0]];
      if (clk_line !== prev && clk_line !== pol)
      begin
        got[n[2:0]] = last; // bit as it stood at the sampling edge
        n++;
      end
      prev = clk_line;
      last = sdo;
    end
    in_frame = 1'b0;
  endtask : run_int
endmodule : ssf_peer

// ### tb/test_sync_serial_flow_control.sv
// test_sync_serial_flow_control: self-checking bench for ssf_top.
// assumes: ssf_pkg compiled first; ssf_peer models the far side.
`timescale 1ns/1ps
module test_sync_serial_flow_control;
  logic mclk;
  logic rst;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic irq;
  logic clk_out;
  logic clk_oe;
  logic peer_clk;
  logic clk_line;
  logic sdi;
  logic sdo;
  logic cts_n;
  logic rdy_n;
  logic [15:0] d;
  logic [7:0] fill;
  logic [7:0] rxb;
  int mismatches;
  int checks_done;
  int seed;

  // clock wire: device drives it while its enable is high
  assign clk_line = clk_oe ? clk_out : peer_clk;

  ssf_top dut_u
  (
    .mclk(mclk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .shift_clock_pin_in(clk_line),
    .shift_clock_pin_out(clk_out),
    .shift_clock_pin_oe(clk_oe),
    .serial_data_in_pin(sdi),
    .serial_data_out_pin(sdo),
    .clear_to_send_in_pin_n(cts_n),
    .ready_to_send_out_pin_n(rdy_n)
  );

  ssf_peer peer_u
  (
    .mclk(mclk),
    .clk_line(clk_line),
    .sdo(sdo),
    .clk_pin(peer_clk),
    .data_pin(sdi),
    .cts_n(cts_n),
    .got()
  );

  // 40 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever
      #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // compare once settled past the edge
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    #1;
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge mclk);
  endtask : rd

  task automatic rc(input logic [2:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rc

  // control word: receive and ready output always on
  function automatic logic [15:0] cfg(input logic te, input logic ext,
    input logic p);
    logic [15:0] v;
    v = 16'h0000;
    v[ssf_pkg::CTRL_TE] = te;
    v[ssf_pkg::CTRL_RE] = 1'b1;
    v[ssf_pkg::CTRL_INT_CLK] = !ext;
    v[ssf_pkg::CTRL_POL] = p;
    v[ssf_pkg::CTRL_CTS_EN] = ext;
    v[ssf_pkg::CTRL_RTS_EN] = 1'b1;
    return v;
  endfunction : cfg

  task automatic wait_idle();
    for (int i = 0; i < 300; i++)
    begin
      rd(ssf_pkg::OFS_STAT, d);
      if (d[ssf_pkg::STAT_BUSY] === 1'b0)
        return;
    end
    mismatches++;
    final_report();
  endtask : wait_idle

  // one internally clocked transfer with fresh filler
  task automatic xfer_int(input logic p);
    fill = 8'($random(seed));
    rxb = 8'($random(seed));
    peer_u.park(p);
    wr(ssf_pkg::OFS_CTRL, cfg(1'b0, 1'b0, p));
    wr(ssf_pkg::OFS_TXBUF, {8'h00, fill});
    fork
      peer_u.run_int(rxb);
      begin
        wr(ssf_pkg::OFS_CTRL, cfg(1'b1, 1'b0, p));
        chk({15'h0000, rdy_n}, 16'h0001);
        chk({15'h0000, clk_oe}, 16'h0001);
      end
    join
    wait_idle();
  endtask : xfer_int

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 7421;
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rc(ssf_pkg::OFS_CTRL, 16'h0000);
    rc(ssf_pkg::OFS_DIV, {8'h00, ssf_pkg::DIV_RST});
    rc(ssf_pkg::OFS_STAT, 16'h0001);
    rc(ssf_pkg::OFS_IRQ_CLR, 16'h0000);
    wr(ssf_pkg::OFS_STAT, 16'hFFFF);
    rc(ssf_pkg::OFS_STAT, 16'h0001);
    wr(ssf_pkg::OFS_DIV, 16'h0007);
    rc(ssf_pkg::OFS_DIV, 16'h0007);
    wr(ssf_pkg::OFS_IRQ_EN, 16'h0007);
    rc(ssf_pkg::OFS_IRQ_EN, 16'h0007);
    // loaded buffer without transmit enable: clock must stay still
    wr(ssf_pkg::OFS_CTRL, cfg(1'b0, 1'b0, 1'b0));
    wr(ssf_pkg::OFS_TXBUF, 16'h00A5);
    for (int i = 0; i < 8; i++)
      rc(ssf_pkg::OFS_STAT, 16'h0000);
    chk({15'h0000, clk_out}, 16'h0001);
    // internal clock, both polarities
    for (int p = 0; p < 2; p++)
    begin
      xfer_int(p[0]);
      chk({8'h00, peer_u.got}, {8'h00, fill});
      rd(ssf_pkg::OFS_RXBUF, d);
      chk({8'h00, d[7:0]}, {8'h00, rxb});
      rc(ssf_pkg::OFS_IRQ_STAT, 16'h0003);
      chk({15'h0000, irq}, 16'h0001);
      wr(ssf_pkg::OFS_IRQ_CLR, 16'h0007);
      chk({15'h0000, irq}, 16'h0000);
    end
    // second word while the first is unread
    wr(ssf_pkg::OFS_IRQ_EN, 16'h0001);
    xfer_int(1'b0);
    wr(ssf_pkg::OFS_IRQ_CLR, 16'h0001);
    xfer_int(1'b0);
    rc(ssf_pkg::OFS_IRQ_STAT, 16'h0006);
    chk({15'h0000, irq}, 16'h0000);
    rc(ssf_pkg::OFS_STAT, 16'h0007);
    wr(ssf_pkg::OFS_IRQ_EN, 16'h0004);
    chk({15'h0000, irq}, 16'h0001);
    rd(ssf_pkg::OFS_RXBUF, d);
    chk({15'h0000, d[ssf_pkg::RXBUF_OVERRUN]}, 16'h0001);
    rc(ssf_pkg::OFS_STAT, 16'h0001);
    wr(ssf_pkg::OFS_IRQ_CLR, 16'h0007);
    wr(ssf_pkg::OFS_IRQ_EN, 16'h0007);
    // external clock with clear-to-send pacing
    for (int p = 0; p < 2; p++)
    begin
      fill = 8'($random(seed));
      rxb = 8'($random(seed));
      peer_u.park(p[0]);
      wr(ssf_pkg::OFS_CTRL, cfg(1'b0, 1'b1, p[0]));
      wr(ssf_pkg::OFS_TXBUF, {8'h00, fill});
      wr(ssf_pkg::OFS_CTRL, cfg(1'b1, 1'b1, p[0]));
      rc(ssf_pkg::OFS_STAT, 16'h0000);
      chk({15'h0000, rdy_n}, 16'h0000);
      chk({15'h0000, clk_oe}, 16'h0000);
      fork
        peer_u.run_ext(rxb);
        begin
          repeat (10) @(posedge mclk);
          chk({15'h0000, rdy_n}, 16'h0001);
        end
      join
      wait_idle();
      rd(ssf_pkg::OFS_RXBUF, d);
      chk({8'h00, d[7:0]}, {8'h00, rxb});
      rc(ssf_pkg::OFS_STAT, 16'h0001);
      wr(ssf_pkg::OFS_IRQ_CLR, 16'h0007);
    end
    final_report();
  end
endmodule : test_sync_serial_flow_control
